/* File: rtl/pgcd_top.sv */
// Control logic of a three-phase gate pre-driver: deadtime, interlock,
// mode locking, fault reporting, APB register port.
// Assumes all inputs synchronous to pclk; enables are also used unsynced.
//
// Notes on behaviour
// R1: Deadtime programmable in 50 ns steps starting from zero.
// R2: Host calibrates the step timebase by a register write.
// R3: By default high and low drive of one phase never both on.
// R4: With simultaneous mode on, the deadtime blanking is skipped.
// R5: Host must write an unlock key with the simultaneous mode write.
// R6: Simultaneous mode write is accepted once per reset, later ignored.
// R7: Operating modes set by a write, then locked until reset; code locks only after a write with MODE_LOCK set.
// R8: Each fault type can be masked from the interrupt.
// R9: Status registers readable by the host.
// R10: Leading edge of a command turns the complementary output off at once.
// R11: Selected output turns on only after the programmed deadtime.
// R12: Deadtime counting starts when the opposing output is commanded off.
// R13: All drives forced off asynchronously unless both enables are high.
// R14: High side refused until its low side was on after enable.
// R15: High commands are active low, low commands active high.
// R16: Reset low resets the logic asynchronously and disables outputs.
// R17: Deadtime counter runs on a timebase, loaded on each command edge.
`timescale 1ns/1ps
module pgcd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_enable_a,
  input wire logic drive_enable_b,
  input wire logic [2:0] phase_high_cmd_n,
  input wire logic [2:0] phase_low_cmd,
  input wire logic desat_fault,
  output logic [2:0] gate_high,
  output logic [2:0] gate_low,
  output logic irq
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [7:0] deadtime;
  logic [7:0] calib;
  logic [3:0] mode;
  logic simul;
  logic simul_done;
  logic [pgcd_pkg::EV_W-1:0] status;
  logic [pgcd_pkg::EV_W-1:0] int_en;
  logic [pgcd_pkg::EV_W-1:0] ev;
  logic [pgcd_pkg::EV_W-1:0] clr;
  logic desat_trip;
  logic en_prev;
  logic step_tick;
  logic gate_rst_n;
  logic drv_ok;
  logic full_on;
  logic zero_dt;
  logic [7:0] dt_load;
  logic [2:0] primed;
  logic [2:0] ev_shoot;
  logic [2:0] ev_refused;
  logic wr;
  logic setup;
  logic hit;
  logic [31:0] rdata;

  // Write access to one register
  function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] target);
    return w && a == target;
  endfunction : wr_hit

  assign full_on = mode[pgcd_pkg::MODE_FULL_ON];
  assign zero_dt = mode[pgcd_pkg::MODE_ZERO_DT];
  // R13 async drive kill
  assign gate_rst_n = presetn & drive_enable_a & drive_enable_b;
  assign drv_ok = drive_enable_a & drive_enable_b & ~desat_trip;
  // R1 zero deadtime option
  assign dt_load = zero_dt ? 8'h00 : deadtime;

  // ------------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------------
  // R17 step timebase
  pgcd_timebase pgcd_timebase_i (
    .pclk(pclk),
    .presetn(presetn),
    .step_cycles(calib),
    .step_tick(step_tick)
  );

  // ------------------------------------------------------------------
  // Phase channels
  // ------------------------------------------------------------------
  for (genvar p = 0; p < 3; p++) begin : g_ph
    logic hi_on;
    logic lo_on;
    logic hi_prev;
    logic lo_prev;
    logic hi_edge;
    logic lo_edge;
    logic both;
    logic rearm_hi;
    logic rearm_lo;
    logic fire_hi;
    logic fire_lo;
    logic [7:0] cnt;
    pgcd_pkg::pgcd_pend_e pend;

    // R15 command polarity
    assign hi_on = ~phase_high_cmd_n[p];
    assign lo_on = phase_low_cmd[p];
    // R10 leading edges
    assign hi_edge = hi_on & ~hi_prev;
    assign lo_edge = lo_on & ~lo_prev;
    assign both = hi_edge & lo_edge;
    // Full-on mode re-arms a held command without a new edge
    assign rearm_hi = full_on & hi_on & ~lo_on & ~gate_high[p]
                      & (pend == pgcd_pkg::PEND_NONE);
    assign rearm_lo = full_on & lo_on & ~hi_on & ~gate_low[p]
                      & (pend == pgcd_pkg::PEND_NONE);
    // R11 turn-on after deadtime
    assign fire_hi = (pend == pgcd_pkg::PEND_HIGH) & (cnt == 8'h00) & hi_on & drv_ok;
    assign fire_lo = (pend == pgcd_pkg::PEND_LOW) & (cnt == 8'h00) & lo_on & drv_ok;
    assign ev_shoot[p] = both & ~simul;
    assign ev_refused[p] = fire_hi & ~primed[p];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hi_prev <= 1'b0;
        lo_prev <= 1'b0;
      end else begin
        hi_prev <= hi_on;
        lo_prev <= lo_on;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend <= pgcd_pkg::PEND_NONE;
        cnt <= 8'h00;
      end else if (!drv_ok || simul || both) begin
        pend <= pgcd_pkg::PEND_NONE;
        cnt <= 8'h00;
      end else if (hi_edge || rearm_hi) begin
        // R12 count from opposing turn-off
        pend <= pgcd_pkg::PEND_HIGH;
        cnt <= dt_load;
      end else if (lo_edge || rearm_lo) begin
        // R12 count from opposing turn-off
        pend <= pgcd_pkg::PEND_LOW;
        cnt <= dt_load;
      end else begin
        unique case (pend)
          pgcd_pkg::PEND_NONE: begin
            cnt <= 8'h00;
          end
          pgcd_pkg::PEND_HIGH: begin
            if (!hi_on || cnt == 8'h00) begin
              pend <= pgcd_pkg::PEND_NONE;
            end else if (step_tick) begin
              // R17 count down per step
              cnt <= cnt - 8'h01;
            end
          end
          pgcd_pkg::PEND_LOW: begin
            if (!lo_on || cnt == 8'h00) begin
              pend <= pgcd_pkg::PEND_NONE;
            end else if (step_tick) begin
              // R17 count down per step
              cnt <= cnt - 8'h01;
            end
          end
          default: begin
            pend <= pgcd_pkg::PEND_NONE;
          end
        endcase
      end
    end

    // R14 bootstrap precharge flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        primed[p] <= 1'b0;
      end else if (!drive_enable_a || !drive_enable_b) begin
        primed[p] <= 1'b0;
      end else if (gate_low[p]) begin
        primed[p] <= 1'b1;
      end
    end

    // R16 outputs cleared by reset, R13 by enables
    always_ff @(posedge pclk or negedge gate_rst_n) begin
      if (!gate_rst_n) begin
        gate_high[p] <= 1'b0;
        gate_low[p] <= 1'b0;
      end else if (!drv_ok) begin
        gate_high[p] <= 1'b0;
        gate_low[p] <= 1'b0;
      end else if (simul) begin
        // R4 no blanking in simultaneous mode
        gate_high[p] <= hi_on & primed[p];
        gate_low[p] <= lo_on;
      end else begin
        // R10 complementary off at once; R3 interlock
        if (!hi_on || lo_edge) begin
          gate_high[p] <= 1'b0;
        end else if (fire_hi && primed[p] && !gate_low[p]) begin
          // R14 high side only once primed
          gate_high[p] <= 1'b1;
        end
        if (!lo_on || hi_edge) begin
          gate_low[p] <= 1'b0;
        end else if (fire_lo && !gate_high[p]) begin
          gate_low[p] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Fault events and desaturation trip
  // ------------------------------------------------------------------
  assign ev[pgcd_pkg::EV_SHOOT] = |ev_shoot;
  assign ev[pgcd_pkg::EV_REFUSED] = |ev_refused;
  assign ev[pgcd_pkg::EV_DISABLE] = en_prev & ~(drive_enable_a & drive_enable_b);
  assign ev[pgcd_pkg::EV_DESAT] = desat_fault;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev <= 1'b0;
    end else begin
      en_prev <= drive_enable_a & drive_enable_b;
    end
  end

  // Desat kills drives only when that behaviour is selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desat_trip <= 1'b0;
    end else if (desat_fault && mode[pgcd_pkg::MODE_DESAT]) begin
      desat_trip <= 1'b1;
    end else if (clr[pgcd_pkg::EV_DESAT]) begin
      desat_trip <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      // Set wins over clear
      status <= (status & ~clr) | ev;
    end
  end

  // R8 per-fault reporting mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & int_en);
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pready;
  assign clr = wr_hit(wr, paddr, pgcd_pkg::ADDR_CLEAR) ? pwdata[pgcd_pkg::EV_W-1:0] : '0;

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      pgcd_pkg::ADDR_DEADTIME: rdata = {24'h00_0000, deadtime};
      pgcd_pkg::ADDR_CALIB: rdata = {24'h00_0000, calib};
      pgcd_pkg::ADDR_MODE: rdata = {28'h000_0000, mode};
      pgcd_pkg::ADDR_SIMUL: rdata = {30'h0000_0000, simul_done, simul};
      // R9 status read back
      pgcd_pkg::ADDR_STATUS: rdata = {28'h000_0000, status};
      pgcd_pkg::ADDR_CLEAR: rdata = 32'h0000_0000;
      pgcd_pkg::ADDR_INT_EN: rdata = {28'h000_0000, int_en};
      pgcd_pkg::ADDR_GATES: begin
        rdata = {21'h00_0000, desat_trip, drive_enable_a & drive_enable_b,
                 primed, gate_low, gate_high};
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= ~hit;
        prdata <= pwrite ? 32'h0000_0000 : rdata;
      end
    end
  end

  // R1 deadtime steps, clamped to range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deadtime <= pgcd_pkg::DEADTIME_RST;
    end else if (wr_hit(wr, paddr, pgcd_pkg::ADDR_DEADTIME)) begin
      deadtime <= (pwdata[7:0] > pgcd_pkg::DT_MAX_STEPS) ? pgcd_pkg::DT_MAX_STEPS
                  : pwdata[7:0];
    end
  end

  // R2 timebase calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calib <= pgcd_pkg::STEP_CYC;
    end else if (wr_hit(wr, paddr, pgcd_pkg::ADDR_CALIB)) begin
      calib <= pwdata[7:0];
    end
  end

  // R7 mode write then lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= pgcd_pkg::MODE_RST;
    end else if (wr_hit(wr, paddr, pgcd_pkg::ADDR_MODE) && !mode[pgcd_pkg::MODE_LOCK]) begin
      mode <= pwdata[3:0];
    end
  end

  // R5 keyed write; R6 once per reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      simul <= 1'b0;
      simul_done <= 1'b0;
    end else if (wr_hit(wr, paddr, pgcd_pkg::ADDR_SIMUL) && !simul_done
                 && pwdata[31:16] == pgcd_pkg::SIMUL_KEY) begin
      simul <= pwdata[0];
      simul_done <= 1'b1;
    end
  end

  // R8 reporting enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en <= pgcd_pkg::INT_EN_RST;
    end else if (wr_hit(wr, paddr, pgcd_pkg::ADDR_INT_EN)) begin
      int_en <= pwdata[pgcd_pkg::EV_W-1:0];
    end
  end

endmodule : pgcd_top

/* File: rtl/pgcd_pkg.sv */
// Constants, register map and types of the phase gate deadtime control.
// Assumes a 40 MHz pclk and a 32-bit APB register port.
package pgcd_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int STEP_NS = 50;
  localparam int DT_MAX_NS = 12000;
  localparam int RESET_MAX_NS = 77;
  localparam logic [7:0] STEP_CYC = 8'((STEP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] DT_MAX_STEPS = 8'(DT_MAX_NS / STEP_NS);

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_DEADTIME = 8'h00;
  localparam logic [7:0] ADDR_CALIB = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_SIMUL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CLEAR = 8'h14;
  localparam logic [7:0] ADDR_INT_EN = 8'h18;
  localparam logic [7:0] ADDR_GATES = 8'h1c;

  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam int MODE_FULL_ON = 0;
  localparam int MODE_DESAT = 1;
  localparam int MODE_ZERO_DT = 2;
  localparam int MODE_LOCK = 3;
  localparam int EV_SHOOT = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_DISABLE = 2;
  localparam int EV_DESAT = 3;
  localparam int EV_W = 4;
  // Arbitrary unlock key for the simultaneous conduction write
  localparam logic [15:0] SIMUL_KEY = 16'h5a3c;
  localparam logic [7:0] DEADTIME_RST = 8'h00;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] INT_EN_RST = 4'h0;

  typedef enum logic [1:0] {PEND_NONE, PEND_HIGH, PEND_LOW} pgcd_pend_e;

endpackage : pgcd_pkg

/* File: rtl/pgcd_timebase.sv */
// Deadtime step timebase: one tick every step_cycles clocks.
// Assumes step_cycles is set by software calibration; 0 acts as 1.
`timescale 1ns/1ps
module pgcd_timebase (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] step_cycles,
  output logic step_tick
);

  logic [7:0] cnt;

  // ------------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      step_tick <= 1'b0;
    end else if ({1'b0, cnt} + 9'h001 >= {1'b0, step_cycles}) begin
      cnt <= 8'h00;
      step_tick <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      step_tick <= 1'b0;
    end
  end

endmodule : pgcd_timebase

/* File: dv/pgcd_host_model.sv */
// Host model: drives phase commands, drive enables and the desat input.
// Assumes the bench calls its tasks from the pclk domain.
`timescale 1ns/1ps
module pgcd_host_model (
  input wire logic pclk,
  output logic drive_enable_a,
  output logic drive_enable_b,
  output logic [2:0] phase_high_cmd_n,
  output logic [2:0] phase_low_cmd,
  output logic desat_fault
);
  initial begin
    phase_high_cmd_n = 3'h7;
    phase_low_cmd = 3'h0;
    desat_fault = 1'b0;
    drive_enable_a = 1'b1;
    drive_enable_b = 1'b1;
  end
  task automatic drive(input logic [2:0] hi_n, input logic [2:0] lo);
    @(posedge pclk);
    phase_high_cmd_n <= hi_n;
    phase_low_cmd <= lo;
  endtask : drive
  task automatic enables(input logic a, input logic b);
    @(posedge pclk);
    drive_enable_a <= a;
    drive_enable_b <= b;
  endtask : enables
  task automatic desat(input logic v);
    @(posedge pclk);
    desat_fault <= v;
  endtask : desat
endmodule : pgcd_host_model

/* File: dv/pgcd_props.sv */
// Checker of the gate control ports, bound into the top module.
// Assumes APB writes take effect at the access edge with pready high.
`timescale 1ns/1ps
module pgcd_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic drive_enable_a,
  input wire logic drive_enable_b,
  input wire logic [2:0] phase_high_cmd_n,
  input wire logic [2:0] phase_low_cmd,
  input wire logic [2:0] gate_high,
  input wire logic [2:0] gate_low,
  input wire logic irq
);
  logic simul_on;
  logic simul_done;
  logic simul_wr;
  assign simul_wr = psel && penable && pready && pwrite && paddr == pgcd_pkg::ADDR_SIMUL
    && pwdata[31:16] == pgcd_pkg::SIMUL_KEY;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      simul_on <= 1'b0;
      simul_done <= 1'b0;
    end else if (simul_wr && !simul_done) begin
      simul_on <= pwdata[0];
      simul_done <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_NO_SHOOT: assert property (!simul_on |-> (gate_high & gate_low) == 3'h0)
    else $error("high and low gate on together");
  AST_EN_OFF: assert property (!(drive_enable_a && drive_enable_b) |->
    gate_high == 3'h0 && gate_low == 3'h0)
    else $error("gate on with enables low");
  AST_RST_REL: assert property ($rose(presetn) |-> gate_high == 3'h0 && gate_low == 3'h0 && !irq)
    else $error("output active after reset");
  AST_LOW_OFF: assert property (!simul_on && $fell(phase_high_cmd_n[0]) |-> ##[1:2] !gate_low[0])
    else $error("low gate kept on after high command");
  AST_HIGH_OFF: assert property (!simul_on && $rose(phase_low_cmd[0]) |-> ##[1:2] !gate_high[0])
    else $error("high gate kept on after low command");
  AST_DT_MIN: assert property (!simul_on && $fell(phase_high_cmd_n[0]) |=> !gate_high[0])
    else $error("high gate on before deadtime");
  AST_HOLD: assert property ($rose(phase_high_cmd_n[0]) |-> ##[1:2] !gate_high[0])
    else $error("high gate kept on after release");
  AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  AST_ERR: assert property (psel && !penable && paddr > 8'h1c |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  cover property ($rose(gate_high[0]));
  cover property ($rose(pslverr));
  cover property ($rose(irq));
  cover property ($rose(simul_on));
endmodule : pgcd_props
bind pgcd_top pgcd_props pgcd_props_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .drive_enable_a(drive_enable_a),
  .drive_enable_b(drive_enable_b), .phase_high_cmd_n(phase_high_cmd_n),
  .phase_low_cmd(phase_low_cmd), .gate_high(gate_high), .gate_low(gate_low), .irq(irq));

/* File: dv/test_pgcd_top.sv */
// Testbench of the phase gate deadtime control: APB tasks and scenarios.
// Assumes the host model drives the phase pins and pclk runs at 40 MHz.
`timescale 1ns/1ps
module test_pgcd_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, err;
  logic drive_enable_a, drive_enable_b, desat_fault;
  logic [2:0] phase_high_cmd_n, phase_low_cmd, gate_high, gate_low;
  logic [31:0] rd;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
  logic [31:0] rv [6] = '{32'h0, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0};
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  always #12.5 pclk = ~pclk;
  pgcd_host_model pgcd_host_model_i (.pclk(pclk), .drive_enable_a(drive_enable_a),
    .drive_enable_b(drive_enable_b), .phase_high_cmd_n(phase_high_cmd_n),
    .phase_low_cmd(phase_low_cmd), .desat_fault(desat_fault));
  pgcd_top pgcd_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive_enable_a(drive_enable_a), .drive_enable_b(drive_enable_b),
    .phase_high_cmd_n(phase_high_cmd_n), .phase_low_cmd(phase_low_cmd),
    .desat_fault(desat_fault), .gate_high(gate_high), .gate_low(gate_low), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Cycles until the chosen phase A gate is seen on
  task automatic measure(input logic high);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((high ? gate_high[0] : gate_low[0]) !== 1'b1 && n < 200);
  endtask : measure
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(ra[i], 1'b0, 32'h0);
      chk(rd, rv[i]);
    end
    apb(8'h20, 1'b0, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("test registers done");
    apb(pgcd_pkg::ADDR_INT_EN, 1'b1, 32'hf);
    pgcd_host_model_i.drive(3'h6, 3'h0);
    repeat (20) @(posedge pclk);
    chk(gate_high, 3'h0);
    chk(irq, 1'b1);
    apb(pgcd_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h2);
    pgcd_host_model_i.drive(3'h7, 3'h0);
    apb(pgcd_pkg::ADDR_CLEAR, 1'b1, 32'hf);
    apb(pgcd_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("test priming done");
    apb(pgcd_pkg::ADDR_DEADTIME, 1'b1, 32'h4);
    apb(pgcd_pkg::ADDR_CALIB, 1'b1, 32'h3);
    pgcd_host_model_i.drive(3'h7, 3'h1);
    measure(1'b0);
    chk(n >= 12 && n <= 20, 1'b1);
    pgcd_host_model_i.drive(3'h6, 3'h1);
    measure(1'b1);
    chk(n >= 12 && n <= 20, 1'b1);
    chk(gate_low, 3'h0);
    pgcd_host_model_i.enables(1'b0, 1'b1);
    #1;
    chk({gate_high, gate_low}, 6'h0);
    pgcd_host_model_i.drive(3'h7, 3'h0);
    pgcd_host_model_i.enables(1'b1, 1'b1);
    apb(pgcd_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h4);
    $display("test deadtime done");
    apb(pgcd_pkg::ADDR_MODE, 1'b1, 32'h7);
    apb(pgcd_pkg::ADDR_MODE, 1'b0, 32'h0);
    chk(rd, 32'h7);
    apb(pgcd_pkg::ADDR_MODE, 1'b1, 32'hf);
    apb(pgcd_pkg::ADDR_MODE, 1'b1, 32'h0);
    apb(pgcd_pkg::ADDR_MODE, 1'b0, 32'h0);
    chk(rd, 32'hf);
    pgcd_host_model_i.drive(3'h7, 3'h1);
    measure(1'b0);
    chk(n, 32'h3);
    pgcd_host_model_i.enables(1'b0, 1'b1);
    pgcd_host_model_i.enables(1'b1, 1'b1);
    measure(1'b0);
    chk(n, 32'h3);
    apb(pgcd_pkg::ADDR_CLEAR, 1'b1, 32'hf);
    apb(pgcd_pkg::ADDR_INT_EN, 1'b1, 32'h7);
    pgcd_host_model_i.desat(1'b1);
    pgcd_host_model_i.desat(1'b0);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    chk(gate_low, 3'h0);
    apb(pgcd_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h8);
    apb(pgcd_pkg::ADDR_INT_EN, 1'b1, 32'hf);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    apb(pgcd_pkg::ADDR_CLEAR, 1'b1, 32'hf);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    $display("test modes done");
    apb(pgcd_pkg::ADDR_SIMUL, 1'b1, 32'h1);
    apb(pgcd_pkg::ADDR_SIMUL, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(pgcd_pkg::ADDR_SIMUL, 1'b1, {pgcd_pkg::SIMUL_KEY, 16'h1});
    apb(pgcd_pkg::ADDR_SIMUL, 1'b1, {pgcd_pkg::SIMUL_KEY, 16'h0});
    apb(pgcd_pkg::ADDR_SIMUL, 1'b0, 32'h0);
    chk(rd, 32'h3);
    pgcd_host_model_i.drive(3'h7, 3'h1);
    repeat (20) @(posedge pclk);
    pgcd_host_model_i.drive(3'h6, 3'h1);
    repeat (4) @(posedge pclk);
    chk({gate_high[0], gate_low[0]}, 2'b11);
    $display("test simultaneous done");
    tally_and_finish();
  end
endmodule : test_pgcd_top
